//--- logic/led_cfg_pkg.sv
// Constants for the common configuration register and its serial access
package led_cfg_pkg;
   localparam int          CFG_W             = 48;
   localparam int          CMD_W             = 16;
   localparam logic [15:0] CMD_WRITE         = 16'hAA00;
   localparam logic [15:0] CMD_READ          = 16'hAA60;
   localparam logic [47:0] CFG_RESET         = 48'h2000_E000_0107;
   localparam int          CASCADE_LSB       = 0;
   localparam int          CASCADE_W         = 5;
   localparam int          PREDISCHARGE_BIT  = 8;
   localparam int          POWER_SAVING_BIT  = 12;
   localparam int          PSP_LSB           = 13;
   localparam int          PSP_W             = 2;
   localparam int          OPEN_REMOVAL_BIT  = 15;
   localparam int          SCAN_LSB          = 16;
   localparam int          SCAN_W            = 6;
   localparam int          SUBP_LSB          = 22;
   localparam int          SUBP_W            = 3;
   localparam int          RANGE_BIT         = 28;
   localparam int          MULT_LSB          = 29;
   localparam int          MULT_W            = 4;
   localparam int          LINE_CHARGE_LSB   = 33;
   localparam int          LINE_CHARGE_W     = 3;
   localparam int          RED_DLY_LSB       = 36;
   localparam int          GREEN_DLY_LSB     = 39;
   localparam int          BLUE_DLY_LSB      = 42;
   localparam int          DLY_W             = 3;
   localparam int          SHORT_REMOVAL_BIT = 47;
   localparam logic [7:0]  SUBP_STEP         = 8'h10;
   localparam logic [3:0]  PSP_QUARTER_8THS  = 4'h2;
   localparam logic [3:0]  PSP_HALF_8THS     = 4'h4;
   localparam logic [3:0]  PSP_SEVEN_8THS    = 4'h7;
   localparam logic [5:0]  CMD_LAST_BIT      = 6'h0F;
   localparam logic [5:0]  DATA_LAST_BIT     = 6'h2F;
endpackage

//--- logic/led_cfg_serial_link.sv
// Serial-clock side: command decode, write capture and read shift-out
`timescale 1ns/1ns
`default_nettype none
module led_cfg_serial_link
   import led_cfg_pkg::*;
(
   input  wire logic             sclk_i,
   input  wire logic             rst_i,
   input  wire logic             frame_i,
   input  wire logic             sin_i,
   output logic                  sout_o,
   output logic [CFG_W-1:0]      wr_word_o,
   output logic                  wr_toggle_o,
   input  wire logic [CFG_W-1:0] rd_word_i,
   input  wire logic             rd_toggle_i
);
   typedef enum logic [1:0] {LINK_CMD, LINK_WRITE, LINK_READ, LINK_SKIP} link_state_t;

   link_state_t      state_reg;
   logic             rst_meta_reg;
   logic             rst_sync_reg;
   logic             rd_meta_reg;
   logic             rd_sync_reg;
   logic             rd_seen_reg;
   logic [CFG_W-1:0] readback_reg;
   logic [CMD_W-1:0] cmd_reg;
   logic [CMD_W-1:0] cmd_next;
   logic [CFG_W-1:0] data_reg;
   logic [CFG_W-1:0] out_reg;
   logic [5:0]       cnt_reg;

   assign cmd_next = {cmd_reg[CMD_W-2:0], sin_i};

   // Reset brought into the serial clock domain
   always_ff @(posedge sclk_i) begin
      rst_meta_reg <= rst_i;
      rst_sync_reg <= rst_meta_reg;
   end

   // Readback copy follows the core register through a toggle handshake
   always_ff @(posedge sclk_i) begin
      if (rst_sync_reg) begin
         rd_meta_reg  <= 1'b0;
         rd_sync_reg  <= 1'b0;
         rd_seen_reg  <= 1'b0;
         readback_reg <= CFG_RESET;
      end else begin
         rd_meta_reg <= rd_toggle_i;
         rd_sync_reg <= rd_meta_reg;
         rd_seen_reg <= rd_sync_reg;
         if (rd_sync_reg != rd_seen_reg) begin
            readback_reg <= rd_word_i;
         end
      end
   end

   // Frame sequencing
   always_ff @(posedge sclk_i) begin
      if (rst_sync_reg || !frame_i) begin
         state_reg <= LINK_CMD;
         cnt_reg   <= 6'h00;
      end else begin
         case (state_reg)
            LINK_CMD: begin
               cnt_reg <= (cnt_reg == CMD_LAST_BIT) ? 6'h00 : cnt_reg + 6'h01;
               if (cnt_reg == CMD_LAST_BIT) begin
                  if (cmd_next == CMD_WRITE) begin
                     state_reg <= LINK_WRITE;
                  end else if (cmd_next == CMD_READ) begin
                     state_reg <= LINK_READ;
                  end else begin
                     state_reg <= LINK_SKIP;
                  end
               end
            end
            LINK_WRITE, LINK_READ: begin
               cnt_reg <= cnt_reg + 6'h01;
               if (cnt_reg == DATA_LAST_BIT) begin
                  state_reg <= LINK_SKIP;
               end
            end
            LINK_SKIP: cnt_reg <= 6'h00;
            default:   state_reg <= LINK_CMD;
         endcase
      end
   end

   // Command and write data shifting
   always_ff @(posedge sclk_i) begin
      if (rst_sync_reg) begin
         cmd_reg     <= 16'h0000;
         data_reg    <= 48'h0000_0000_0000;
         wr_word_o   <= CFG_RESET;
         wr_toggle_o <= 1'b0;
      end else if (frame_i) begin
         if (state_reg == LINK_CMD) begin
            cmd_reg <= cmd_next;
         end
         if (state_reg == LINK_WRITE) begin
            data_reg <= {data_reg[CFG_W-2:0], sin_i};
            if (cnt_reg == DATA_LAST_BIT) begin
               wr_word_o   <= {data_reg[CFG_W-2:0], sin_i};
               wr_toggle_o <= ~wr_toggle_o;
            end
         end
      end
   end

   // Read data out, most significant bit first
   always_ff @(posedge sclk_i) begin
      if (rst_sync_reg || !frame_i) begin
         out_reg <= 48'h0000_0000_0000;
         sout_o  <= 1'b0;
      end else if (state_reg == LINK_CMD && cnt_reg == CMD_LAST_BIT) begin
         out_reg <= readback_reg;
         sout_o  <= 1'b0;
      end else if (state_reg == LINK_READ) begin
         out_reg <= {out_reg[CFG_W-2:0], 1'b0};
         sout_o  <= out_reg[CFG_W-1];
      end else begin
         sout_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- logic/led_driver_common_config_reg.sv
// Common configuration register with decoded controls and line counter
`timescale 1ns/1ns
`default_nettype none
module led_driver_common_config_reg
   import led_cfg_pkg::*;
#(
   parameter int GS_W  = 16,
   parameter int SEG_W = 11
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             sclk_i,
   input  wire logic             frame_i,
   input  wire logic             sin_i,
   output logic                  sout_o,
   input  wire logic [GS_W-1:0]  channel_grayscale_value_i,
   input  wire logic [SEG_W-1:0] segment_length_i,
   input  wire logic             forward_pwm_mode_i,
   input  wire logic             line_advance_i,
   output logic [5:0]            device_count_o,
   output logic                  predischarge_enable_o,
   output logic                  power_saving_enable_o,
   output logic [1:0]            power_saving_plus_select_o,
   output logic                  power_saving_plus_active_o,
   output logic                  open_led_removal_enable_o,
   output logic [6:0]            scan_line_count_o,
   output logic [7:0]            subperiod_count_o,
   output logic                  multiplier_range_select_o,
   output logic [4:0]            multiplier_factor_o,
   output logic [2:0]            line_charge_setting_o,
   output logic [2:0]            red_group_delay_o,
   output logic [2:0]            green_group_delay_o,
   output logic [2:0]            blue_group_delay_o,
   output logic                  short_led_removal_enable_o,
   output logic [5:0]            line_index_o,
   output logic                  frame_complete_o,
   output logic [CFG_W-1:0]      config_word_o
);
   logic [CFG_W-1:0]  common_config_zero_reg;
   logic [CFG_W-1:0]  link_word;
   logic              link_toggle;
   logic              wr_meta_reg;
   logic              wr_sync_reg;
   logic              wr_seen_reg;
   logic              wr_apply;
   logic              pub_toggle_reg;
   logic [5:0]        line_cnt_reg;
   logic [1:0]        psp_sel;
   logic [3:0]        psp_eighths;
   logic [GS_W+2:0]   gs_scaled;
   logic [SEG_W+2:0]  seg_scaled;

   function automatic logic [6:0] code_plus_one(input logic [5:0] code);
      return {1'b0, code} + 7'h01;
   endfunction

   led_cfg_serial_link u_link (
      .sclk_i      (sclk_i),
      .rst_i       (rst_i),
      .frame_i     (frame_i),
      .sin_i       (sin_i),
      .sout_o      (sout_o),
      .wr_word_o   (link_word),
      .wr_toggle_o (link_toggle),
      .rd_word_i   (common_config_zero_reg),
      .rd_toggle_i (pub_toggle_reg)
   );

   assign wr_apply = wr_sync_reg ^ wr_seen_reg;

   // Write event crossing; runs through reset so an old toggle is not replayed
   always_ff @(posedge clk_i) begin
      wr_meta_reg <= link_toggle;
      wr_sync_reg <= wr_meta_reg;
      wr_seen_reg <= wr_sync_reg;
   end

   // Register storage, whole word taken from a completed write frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         common_config_zero_reg <= CFG_RESET;
         pub_toggle_reg         <= 1'b0;
      end else if (wr_apply) begin
         common_config_zero_reg <= link_word;
         pub_toggle_reg         <= ~pub_toggle_reg;
      end
   end

   assign config_word_o = common_config_zero_reg;

   // Plain enables and selects
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         predischarge_enable_o      <= CFG_RESET[PREDISCHARGE_BIT];
         power_saving_enable_o      <= CFG_RESET[POWER_SAVING_BIT];
         power_saving_plus_select_o <= CFG_RESET[PSP_LSB +: PSP_W];
         open_led_removal_enable_o  <= CFG_RESET[OPEN_REMOVAL_BIT];
         multiplier_range_select_o  <= CFG_RESET[RANGE_BIT];
         line_charge_setting_o      <= CFG_RESET[LINE_CHARGE_LSB +: LINE_CHARGE_W];
         short_led_removal_enable_o <= CFG_RESET[SHORT_REMOVAL_BIT];
      end else begin
         predischarge_enable_o      <= common_config_zero_reg[PREDISCHARGE_BIT];
         power_saving_enable_o      <= common_config_zero_reg[POWER_SAVING_BIT];
         power_saving_plus_select_o <= common_config_zero_reg[PSP_LSB +: PSP_W];
         open_led_removal_enable_o  <= common_config_zero_reg[OPEN_REMOVAL_BIT];
         multiplier_range_select_o  <= common_config_zero_reg[RANGE_BIT];
         line_charge_setting_o      <= common_config_zero_reg[LINE_CHARGE_LSB +: LINE_CHARGE_W];
         short_led_removal_enable_o <= common_config_zero_reg[SHORT_REMOVAL_BIT];
      end
   end

   // Counts decoded from their codes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         device_count_o      <= 6'h08;
         scan_line_count_o   <= 7'h01;
         subperiod_count_o   <= SUBP_STEP;
         multiplier_factor_o <= 5'h08;
      end else begin
         device_count_o <= 6'(code_plus_one({1'b0,
            common_config_zero_reg[CASCADE_LSB +: CASCADE_W]}));
         scan_line_count_o <= code_plus_one(common_config_zero_reg[SCAN_LSB +: SCAN_W]);
         subperiod_count_o <= {1'b0, common_config_zero_reg[SUBP_LSB +: SUBP_W], 4'h0}
            + SUBP_STEP;
         multiplier_factor_o <= 5'(code_plus_one({2'b00,
            common_config_zero_reg[MULT_LSB +: MULT_W]}));
      end
   end

   // Group delays, zero outside forward mode
   always_ff @(posedge clk_i) begin
      if (rst_i || !forward_pwm_mode_i) begin
         red_group_delay_o   <= 3'h0;
         green_group_delay_o <= 3'h0;
         blue_group_delay_o  <= 3'h0;
      end else begin
         red_group_delay_o   <= common_config_zero_reg[RED_DLY_LSB +: DLY_W];
         green_group_delay_o <= common_config_zero_reg[GREEN_DLY_LSB +: DLY_W];
         blue_group_delay_o  <= common_config_zero_reg[BLUE_DLY_LSB +: DLY_W];
      end
   end

   // Power-saving-plus threshold compare in eighths of a segment
   assign psp_sel = common_config_zero_reg[PSP_LSB +: PSP_W];

   always_comb begin
      case (psp_sel)
         2'b01:   psp_eighths = PSP_QUARTER_8THS;
         2'b10:   psp_eighths = PSP_HALF_8THS;
         2'b11:   psp_eighths = PSP_SEVEN_8THS;
         default: psp_eighths = 4'h0;
      endcase
   end

   assign gs_scaled  = {channel_grayscale_value_i, 3'b000};
   assign seg_scaled = {3'b000, segment_length_i} * {{(SEG_W-1){1'b0}}, psp_eighths};

   always_ff @(posedge clk_i) begin
      if (rst_i || psp_sel == 2'b00) begin
         power_saving_plus_active_o <= 1'b0;
      end else begin
         power_saving_plus_active_o <= gs_scaled <= {{(GS_W-SEG_W){1'b0}}, seg_scaled};
      end
   end

   // Line counter wraps once it passes the configured scan lines
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_cnt_reg     <= 6'h00;
         frame_complete_o <= 1'b0;
      end else begin
         frame_complete_o <= 1'b0;
         if (line_advance_i) begin
            if (line_cnt_reg == common_config_zero_reg[SCAN_LSB +: SCAN_W]) begin
               line_cnt_reg     <= 6'h00;
               frame_complete_o <= 1'b1;
            end else begin
               line_cnt_reg <= line_cnt_reg + 6'h01;
            end
         end
      end
   end

   assign line_index_o = line_cnt_reg;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_write_applied;
      wr_apply ##1 1'b1;
   endsequence

   sequence s_decode_settled;
      ##1 1'b1;
   endsequence

   AST_WRITE_TAKES_WORD: assert property (
      wr_apply |=> common_config_zero_reg == $past(link_word))
      else $error("written word not stored");

   AST_CASCADE_COUNT: assert property (
      s_write_applied |-> s_decode_settled ##0
      device_count_o == 6'({1'b0, $past(link_word[4:0], 2)} + 6'h01))
      else $error("device count wrong");

   AST_PREDISCHARGE_AFTER_RESET: assert property (
      $fell(rst_i) |-> predischarge_enable_o && !power_saving_enable_o)
      else $error("pre-discharge or power saving reset state wrong");

   AST_POWER_SAVING_FOLLOWS: assert property (
      s_write_applied |-> s_decode_settled ##0
      power_saving_enable_o == $past(link_word[12], 2))
      else $error("power saving enable wrong");

   AST_PLUS_DISABLED: assert property (
      psp_sel == 2'b00 |=> !power_saving_plus_active_o)
      else $error("plus mode active while disabled");

   AST_PLUS_QUARTER: assert property (
      psp_sel == 2'b01 && {1'b0, channel_grayscale_value_i, 2'b00} > {8'h00, segment_length_i}
      |=> !power_saving_plus_active_o)
      else $error("plus quarter threshold wrong");

   AST_OPEN_AND_SHORT_REMOVAL: assert property (
      s_write_applied |-> s_decode_settled ##0
      open_led_removal_enable_o == $past(link_word[15], 2) &&
      short_led_removal_enable_o == $past(link_word[47], 2))
      else $error("removal enables wrong");

   AST_SCAN_LINES: assert property (
      s_write_applied |-> s_decode_settled ##0
      scan_line_count_o == {1'b0, $past(link_word[21:16], 2)} + 7'h01)
      else $error("scan line count wrong");

   AST_SUBPERIODS: assert property (
      s_write_applied |-> s_decode_settled ##0
      subperiod_count_o == {1'b0, $past(link_word[24:22], 2), 4'h0} + 8'h10)
      else $error("sub-period count wrong");

   AST_MULTIPLIER: assert property (
      s_write_applied |-> s_decode_settled ##0
      multiplier_factor_o == {1'b0, $past(link_word[32:29], 2)} + 5'h01 &&
      multiplier_range_select_o == $past(link_word[28], 2))
      else $error("multiplier setting wrong");

   AST_DELAY_FORWARD_ONLY: assert property (
      !forward_pwm_mode_i |=> red_group_delay_o == 3'h0 &&
      green_group_delay_o == 3'h0 && blue_group_delay_o == 3'h0)
      else $error("group delay outside forward mode");

   AST_FRAME_WRAP: assert property (
      line_advance_i && line_cnt_reg == common_config_zero_reg[21:16]
      |=> frame_complete_o && line_cnt_reg == 6'h00 ##1
      (!frame_complete_o || $past(line_advance_i)) [*1])
      else $error("frame completion wrong");

   AST_FRAME_NOT_EARLY: assert property (
      line_advance_i && line_cnt_reg != common_config_zero_reg[21:16]
      |=> !frame_complete_o && line_cnt_reg == $past(line_cnt_reg) + 6'h01)
      else $error("line count advance wrong");

   AST_PREDISCHARGE_FOLLOWS: assert property (
      s_write_applied |-> s_decode_settled ##0
      predischarge_enable_o == $past(link_word[8], 2))
      else $error("pre-discharge enable wrong");

   AST_PLUS_SELECT_FOLLOWS: assert property (
      s_write_applied |-> s_decode_settled ##0
      power_saving_plus_select_o == $past(link_word[14:13], 2))
      else $error("plus select wrong");

   AST_LINE_CHARGE_FOLLOWS: assert property (
      s_write_applied |-> s_decode_settled ##0
      line_charge_setting_o == $past(link_word[35:33], 2))
      else $error("line charge setting wrong");

   AST_COUNTS_AFTER_RESET: assert property (
      $fell(rst_i) |-> device_count_o == 6'h08 && scan_line_count_o == 7'h01 &&
      subperiod_count_o == 8'h10 && multiplier_factor_o == 5'h08)
      else $error("decoded counts after reset wrong");

   AST_COUNT_RANGES: assert property (
      device_count_o != 6'h00 && device_count_o <= 6'h20 &&
      scan_line_count_o != 7'h00 && scan_line_count_o <= 7'h40)
      else $error("device or scan count out of range");

   AST_PLUS_QUARTER_ACTIVE: assert property (
      psp_sel == 2'b01 && {1'b0, channel_grayscale_value_i, 2'b00} <= {8'h00, segment_length_i}
      |=> power_saving_plus_active_o)
      else $error("plus quarter not active");

   AST_PLUS_HALF: assert property (
      psp_sel == 2'b10 && {2'b00, channel_grayscale_value_i, 1'b0} > {8'h00, segment_length_i}
      |=> !power_saving_plus_active_o)
      else $error("plus half threshold wrong");

   AST_PLUS_HALF_ACTIVE: assert property (
      psp_sel == 2'b10 && {2'b00, channel_grayscale_value_i, 1'b0} <= {8'h00, segment_length_i}
      |=> power_saving_plus_active_o)
      else $error("plus half not active");

   AST_PLUS_SEVEN: assert property (
      psp_sel == 2'b11 && {channel_grayscale_value_i, 3'b000} >
      {5'h00, segment_length_i, 3'b000} - {8'h00, segment_length_i}
      |=> !power_saving_plus_active_o)
      else $error("plus seven eighths threshold wrong");

   AST_PLUS_SEVEN_ACTIVE: assert property (
      psp_sel == 2'b11 && {channel_grayscale_value_i, 3'b000} <=
      {5'h00, segment_length_i, 3'b000} - {8'h00, segment_length_i}
      |=> power_saving_plus_active_o)
      else $error("plus seven eighths not active");

   AST_DELAY_FORWARD_VALUES: assert property (
      forward_pwm_mode_i |=> red_group_delay_o == $past(common_config_zero_reg[38:36]) &&
      green_group_delay_o == $past(common_config_zero_reg[41:39]) &&
      blue_group_delay_o == $past(common_config_zero_reg[44:42]))
      else $error("group delay value wrong");

   AST_WORD_HOLDS: assert property (
      !wr_apply |=> $stable(common_config_zero_reg) && $stable(pub_toggle_reg))
      else $error("register changed without a write");

   AST_READ_PUBLISH: assert property (
      wr_apply |=> pub_toggle_reg != $past(pub_toggle_reg))
      else $error("write not published to readback");
endmodule
`default_nettype wire

//--- verif/led_host_model.sv
// Host controller model driving the serial configuration link
`timescale 1ns/1ns
`default_nettype none
module led_host_model (
   input  wire logic sclk_i,
   output logic      frame_o,
   output logic      sin_o,
   input  wire logic sout_i
);
   logic [63:0] word;
   initial begin
      frame_o = 1'b0;
      sin_o   = 1'b0;
   end
   // Command then data, MSB first; frame dropped after nbits
   task automatic xfer(input logic [15:0] cmd, input logic [47:0] data,
                       input int nbits, output logic [47:0] rd);
      word = {cmd, data};
      for (int i = 0; i <= 64; i++) begin
         @(negedge sclk_i);
         if (i >= 17) rd[64-i] = sout_i;
         if (i < nbits) begin
            frame_o = 1'b1;
            sin_o   = word[63-i];
         end else begin
            frame_o = 1'b0;
            sin_o   = ~sin_o;
         end
      end
   endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Testbench for the common configuration register and its serial link
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import led_cfg_pkg::*;
;
   localparam logic [47:0] RST_W = 48'h2000_E000_0107;
   localparam logic [47:0] RSVD  = 48'h6000_0E00_0EE0;
   logic        clk_i;
   logic        rst_i;
   logic        sclk_i;
   logic        frame_i;
   logic        sin_i;
   logic        sout_o;
   logic [15:0] gs_i;
   logic [10:0] seg_i;
   logic        fwd_i;
   logic        adv_i;
   logic [5:0]  dev_o;
   logic        pdc_o;
   logic        ps_o;
   logic [1:0]  psp_o;
   logic        pspa_o;
   logic        open_o;
   logic [6:0]  scan_o;
   logic [7:0]  subp_o;
   logic        rng_o;
   logic [4:0]  mul_o;
   logic [2:0]  chg_o;
   logic [2:0]  red_o;
   logic [2:0]  grn_o;
   logic [2:0]  blu_o;
   logic        shrt_o;
   logic [5:0]  idx_o;
   logic        fc_o;
   logic [47:0] cfg_o;
   int          fails = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          fc_cnt = 0;
   logic [47:0] rd;
   logic [47:0] cur;
   logic [47:0] words [4];

   led_driver_common_config_reg dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .frame_i(frame_i), .sin_i(sin_i),
      .sout_o(sout_o), .channel_grayscale_value_i(gs_i), .segment_length_i(seg_i),
      .forward_pwm_mode_i(fwd_i), .line_advance_i(adv_i), .device_count_o(dev_o),
      .predischarge_enable_o(pdc_o), .power_saving_enable_o(ps_o),
      .power_saving_plus_select_o(psp_o), .power_saving_plus_active_o(pspa_o),
      .open_led_removal_enable_o(open_o), .scan_line_count_o(scan_o),
      .subperiod_count_o(subp_o), .multiplier_range_select_o(rng_o),
      .multiplier_factor_o(mul_o), .line_charge_setting_o(chg_o), .red_group_delay_o(red_o),
      .green_group_delay_o(grn_o), .blue_group_delay_o(blu_o),
      .short_led_removal_enable_o(shrt_o), .line_index_o(idx_o), .frame_complete_o(fc_o),
      .config_word_o(cfg_o));

   led_host_model host_u (.sclk_i(sclk_i), .frame_o(frame_i), .sin_o(sin_i), .sout_i(sout_o));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      sclk_i = 1'b0;
      #3;
      forever #16 sclk_i = ~sclk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (fc_o === 1'b1) fc_cnt++;
      if (cycles == 30000) begin
         fails++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [47:0] w);
      cur = (w & ~RSVD) | (RST_W & RSVD);
      host_u.xfer(CMD_WRITE, cur, 64, rd);
      repeat (12) @(posedge sclk_i);
   endtask

   task automatic rdchk(input logic [47:0] exp);
      host_u.xfer(CMD_READ, 48'h0, 64, rd);
      chk("link_read", exp, rd);
      chk("config_word", exp, cfg_o);
   endtask

   task automatic dec(input logic [47:0] w);
      int k;
      k = (w[14:13] == 2'h1) ? 2 : (w[14:13] == 2'h2) ? 4 : (w[14:13] == 2'h3) ? 7 : 0;
      @(negedge clk_i);
      chk("devices", 48'(w[4:0]) + 1, 48'(dev_o));
      chk("predischarge", 48'(w[8]), 48'(pdc_o));
      chk("power_saving", 48'(w[12]), 48'(ps_o));
      chk("psp_select", 48'(w[14:13]), 48'(psp_o));
      chk("open_removal", 48'(w[15]), 48'(open_o));
      chk("scan_lines", 48'(w[21:16]) + 1, 48'(scan_o));
      chk("subperiods", (48'(w[24:22]) + 1) * 16, 48'(subp_o));
      chk("range", 48'(w[28]), 48'(rng_o));
      chk("multiplier", 48'(w[32:29]) + 1, 48'(mul_o));
      chk("line_charge", 48'(w[35:33]), 48'(chg_o));
      chk("delays", 48'(w[44:36]), 48'({blu_o, grn_o, red_o}));
      chk("short_removal", 48'(w[47]), 48'(shrt_o));
      for (int d = 0; d < 2; d++) begin
         gs_i = 16'(800 * k / 8 + d);
         repeat (3) @(negedge clk_i);
         chk("psp_active", 48'(k != 0 && d == 0), 48'(pspa_o));
      end
      fwd_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("delays_off", 48'h0, 48'({blu_o, grn_o, red_o}));
      fwd_i = 1'b1;
   endtask

   task automatic lines(input logic [5:0] s);
      fc_cnt = 0;
      if (s != 6'h00) begin
         adv_i = 1'b1;
         repeat (int'(s)) @(negedge clk_i);
         adv_i = 1'b0;
      end
      repeat (3) @(negedge clk_i);
      chk("early_frames", 48'h0, 48'(fc_cnt));
      chk("line_index", 48'(s), 48'(idx_o));
      adv_i = 1'b1;
      @(negedge clk_i);
      adv_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("frame_done", 48'h1, 48'(fc_cnt));
      chk("line_wrap", 48'h0, 48'(idx_o));
   endtask

   initial begin
      rst_i = 1'b1;
      gs_i  = 16'h0000;
      seg_i = 11'h320;
      fwd_i = 1'b1;
      adv_i = 1'b0;
      cur   = RST_W;
      words = '{48'hFFFF_FFFF_FFFF, 48'h0, 48'h5555_5555_5555, 48'hAAAA_AAAA_AAAA};
      repeat (4) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (10) @(posedge sclk_i);
      dec(RST_W);
      lines(6'h00);
      rdchk(RST_W);
      foreach (words[i]) begin
         wr(words[i]);
         dec(cur);
         lines(cur[21:16]);
         rdchk(cur);
      end
      @(negedge clk_i);
      rst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      rst_i = 1'b0;
      cur = RST_W;
      repeat (10) @(posedge sclk_i);
      dec(RST_W);
      rdchk(RST_W);
      host_u.xfer(16'hAA01, 48'h0, 64, rd);
      repeat (12) @(posedge sclk_i);
      rdchk(RST_W);
      host_u.xfer(CMD_WRITE, ~RST_W, 40, rd);
      repeat (12) @(posedge sclk_i);
      rdchk(RST_W);
      test_done();
   end
endmodule
`default_nettype wire
